// File: inc/vdram_host_pkg.sv
// Constants, command codes and pin bundle for the video DRAM port controller
package vdram_host_pkg;
  // Clock and strobe timing, in ns and in whole cycles (least times round up)
  localparam int CLK_NS = 4;
  localparam int T_RP_NS = 60;  // Row strobe precharge
  localparam int T_RCD_NS = 20;  // Row fall to column fall
  localparam int T_CAS_NS = 20;  // Column strobe low
  localparam int T_CP_NS = 12;  // Column strobe high
  localparam int T_RAS_NS = 70;  // Row strobe low remainder
  localparam logic [7:0] RP_CYC = 8'((T_RP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] RCD_CYC = 8'((T_RCD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] CAS_CYC = 8'((T_CAS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] CP_CYC = 8'((T_CP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] RAS_CYC = 8'((T_RAS_NS + CLK_NS - 1) / CLK_NS);
  // Register offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_DATA = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  // Command field positions
  localparam int CMD_PIPE = 4;
  localparam int CMD_WR = 5;
  localparam int CMD_KEEP = 6;
  localparam int CMD_BLK = 7;
  // Address register: row in [8:0], column in [17:9]
  localparam int ADDR_COL = 9;
  // Data register: column-time data [7:0], row-time plane mask [15:8]
  localparam int DATA_MASK = 8;
  // Cycle kinds chosen by software, codes in listed order
  typedef enum logic [3:0] {
    refresh_with_option_reset, refresh_with_stop_set, refresh_only,
    masked_write_transfer, masked_split_write_transfer, read_transfer,
    split_read_transfer, masked_read_write, masked_block_write, flash_write,
    read_write, unmasked_block_write, load_write_mask, load_color
  } op_t;
  // Levels that one cycle kind needs
  typedef struct packed {
    logic rfsh;  // Column strobe low before row fall
    logic toe;  // Transfer/output-enable level at row fall
    logic wpb;  // Write-per-bit/write-enable level at row fall
    logic fs1;  // Function select one at row fall
    logic cas;  // Cycle has a column strobe
    logic cfs1;  // Function select one at column fall
    logic cwr;  // Column cycle writes data
  } lev_t;
  // Device control pins, strobes active low
  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic transfer_or_output_enable_n;
    logic write_per_bit_or_write_enable_n;
    logic function_select_one;
    logic pipeline_select;
    logic [8:0] addr;
  } dram_ctl_t;
endpackage

// File: verilog/vdram_host.sv
// Host-side controller that sequences the RAM port pins of a video DRAM
// Summary of operation
// - Column low at row fall: refresh variants
// - Transfer low at row fall: RAM-SAM transfer
// - Masked page, select low at column: masked read/write
// - Select high at column fall: block write
// - Masked, select one high: flash write, no column
// - Unmasked page, select low: extended page read/write
// - Pipeline select high: pipelined page timing
// - All high: load mask or color register
// - Column mask on data pins, pins one-four
// - Masked block write: plane mask at row fall
// - Nine row bits, then nine column bits
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ns
module vdram_host (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output vdram_host_pkg::dram_ctl_t dram_ctl,
  output logic [7:0] data_o,
  output logic data_oe,
  input wire logic [7:0] data_i
);
  import vdram_host_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  typedef enum logic [2:0] {
    S_IDLE, S_SETUP, S_RAS, S_CAS, S_CASH, S_HOLD, S_PRE
  } state_t;
  state_t st_q, st_d;  // Sequencer state
  logic [7:0] cnt_q, cnt_d;  // Cycles left in a state
  op_t op_q;  // Kind set when the row opened
  logic pipe_q, wr_q, keep_q, blk_q;  // Command bits
  logic [8:0] row_q, col_q;  // Multiplexed address halves
  logic [7:0] cdat_q, mask_q;  // Column data, row-time plane mask
  logic [7:0] rdat_q;  // Last data read
  logic old_q;  // Old mask mode tracked
  logic stop_q;  // Binary boundaries set
  logic open_q;  // Row left open for more columns
  logic [7:0] din_s1, din_s2;  // Data pin synchroniser
  dram_ctl_t ctl_q;  // Registered pin levels
  logic [7:0] dout_q;  // Registered data pins
  logic doe_q;  // Registered data drive
  lev_t lev;  // Levels of the current kind
  logic fam, done, idle, go, in_row, in_col, rd_c, wr_c, cas_fs1;
  logic ras_lo, cas_lo, drv_mask, drv_data;
  logic wr_cmd, wr_addr, wr_data, rd_stat, rd_data;
  op_t op_w;

  ////////////////////////////////////////////////////////////////////////////
  // Level table per cycle kind
  function automatic lev_t levels(input op_t op);
    lev_t l;
    l = '{rfsh: 1'b0, toe: 1'b1, wpb: 1'b1, fs1: 1'b0, cas: 1'b1,
          cfs1: 1'b0, cwr: 1'b0};
    case (op)
      refresh_with_option_reset: begin
        l.rfsh = 1'b1;
        l.cas = 1'b0;
      end
      refresh_with_stop_set: begin
        l.rfsh = 1'b1;
        l.wpb = 1'b0;
        l.fs1 = 1'b1;
        l.cas = 1'b0;
      end
      refresh_only: begin
        l.rfsh = 1'b1;
        l.fs1 = 1'b1;
        l.cas = 1'b0;
      end
      masked_write_transfer: begin
        l.toe = 1'b0;
        l.wpb = 1'b0;
      end
      masked_split_write_transfer: begin
        l.toe = 1'b0;
        l.wpb = 1'b0;
        l.fs1 = 1'b1;
      end
      read_transfer: l.toe = 1'b0;
      split_read_transfer: begin
        l.toe = 1'b0;
        l.fs1 = 1'b1;
      end
      masked_read_write, masked_block_write: l.wpb = 1'b0;
      flash_write: begin
        l.wpb = 1'b0;
        l.fs1 = 1'b1;
        l.cas = 1'b0;
      end
      load_write_mask: begin
        l.fs1 = 1'b1;
        l.cwr = 1'b1;
      end
      load_color: begin
        l.fs1 = 1'b1;
        l.cfs1 = 1'b1;
        l.cwr = 1'b1;
      end
      default: l.cas = 1'b1;  // Unmasked page kinds
    endcase
    return l;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register port decode
  assign wr_cmd = wr && (addr == OFF_CMD);
  assign wr_addr = wr && (addr == OFF_ADDR);
  assign wr_data = wr && (addr == OFF_DATA);
  assign rd_stat = rd && (addr == OFF_STAT);
  assign rd_data = rd && (addr == OFF_DATA);
  assign op_w = op_t'(wdata[3:0]);
  assign idle = (st_q == S_IDLE);
  assign go = wr_cmd && idle;  // Commands while busy are dropped

  ////////////////////////////////////////////////////////////////////////////
  // Cycle decode
  assign lev = levels(op_q);
  assign fam = (op_q == masked_read_write) || (op_q == masked_block_write) ||
               (op_q == read_write) || (op_q == unmasked_block_write);
  assign cas_fs1 = fam ? blk_q : lev.cfs1;
  assign wr_c = fam ? (blk_q || wr_q) : lev.cwr;
  assign rd_c = fam && !blk_q && !wr_q;
  assign done = (cnt_q == 8'h00);
  assign in_row = (st_q == S_SETUP) || (st_q == S_RAS);
  assign in_col = (st_q == S_CAS) || (st_q == S_CASH);
  assign ras_lo = (st_q == S_RAS) || in_col || (st_q == S_HOLD) ||
                  (idle && open_q);
  assign cas_lo = (st_q == S_CAS) || (lev.rfsh && in_row);
  // Plane mask at row fall only in new mask mode
  assign drv_mask = in_row && !lev.wpb && !lev.rfsh && !old_q;
  // Column data with write strobe low at column fall
  assign drv_data = in_col && wr_c;

  ////////////////////////////////////////////////////////////////////////////
  // Next state and timer
  always_comb begin
    st_d = st_q;
    case (st_q)
      S_IDLE: begin
        if (go) begin
          st_d = open_q ? S_CAS : S_SETUP;
        end
      end
      S_SETUP: if (done) st_d = S_RAS;
      S_RAS: if (done) st_d = lev.cas ? S_CAS : S_HOLD;
      S_CAS: if (done) st_d = S_CASH;
      S_CASH: if (done) st_d = S_HOLD;
      S_HOLD: if (done) st_d = keep_q ? S_IDLE : S_PRE;
      S_PRE: if (done) st_d = S_IDLE;
      default: st_d = S_IDLE;
    endcase
  end

  // Timer reload on each state change
  always_comb begin
    cnt_d = done ? 8'h00 : cnt_q - 8'h01;
    if (st_d != st_q) begin
      case (st_d)
        S_SETUP, S_PRE: cnt_d = RP_CYC;
        S_RAS: cnt_d = RCD_CYC;
        S_CAS: cnt_d = CAS_CYC;
        S_CASH: cnt_d = CP_CYC;
        S_HOLD: cnt_d = RAS_CYC;
        default: cnt_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= S_IDLE;
      cnt_q <= 8'h00;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command, address and data registers
  always_ff @(posedge clk) begin
    if (srst) begin
      op_q <= refresh_with_option_reset;
      {pipe_q, wr_q, keep_q, blk_q} <= 4'h0;
    end else if (go) begin
      if (!open_q) begin
        op_q <= op_w;  // Row-time kind only set on a new row
        pipe_q <= wdata[CMD_PIPE];
      end
      wr_q <= wdata[CMD_WR];
      blk_q <= wdata[CMD_BLK] || (!open_q && ((op_w == masked_block_write) ||
               (op_w == unmasked_block_write)));
      keep_q <= wdata[CMD_KEEP] && (open_q || (op_w == masked_read_write) ||
                (op_w == masked_block_write) || (op_w == read_write) ||
                (op_w == unmasked_block_write));
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      row_q <= 9'h000;
      col_q <= 9'h000;
    end else if (wr_addr) begin
      row_q <= wdata[8:0];
      col_q <= wdata[ADDR_COL +: 9];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cdat_q <= 8'h00;
      mask_q <= 8'h00;
    end else if (wr_data) begin
      cdat_q <= wdata[7:0];
      mask_q <= wdata[DATA_MASK +: 8];
    end
  end

  // Mode tracking as commands are taken
  always_ff @(posedge clk) begin
    if (srst) begin
      old_q <= 1'b0;
      stop_q <= 1'b0;
    end else if (go && !open_q) begin
      if (op_w == load_write_mask) begin
        old_q <= 1'b1;
      end else if (op_w == refresh_with_option_reset) begin
        old_q <= 1'b0;
      end
      if (op_w == refresh_with_stop_set) begin
        stop_q <= 1'b1;
      end else if (op_w == refresh_with_option_reset) begin
        stop_q <= 1'b0;
      end
    end
  end

  // Page open flag
  always_ff @(posedge clk) begin
    if (srst) begin
      open_q <= 1'b0;
    end else if (st_q == S_HOLD && done) begin
      open_q <= keep_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data capture
  always_ff @(posedge clk) begin
    din_s1 <= data_i;
    din_s2 <= din_s1;
  end

  // Sampled late, data still held past column rise
  always_ff @(posedge clk) begin
    if (srst) begin
      rdat_q <= 8'h00;
    end else if (st_q == S_CASH && done && rd_c) begin
      rdat_q <= din_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive
  always_ff @(posedge clk) begin
    if (srst) begin
      ctl_q <= '{ras_n: 1'b1, cas_n: 1'b1, transfer_or_output_enable_n: 1'b1,
                 write_per_bit_or_write_enable_n: 1'b1, function_select_one: 1'b0,
                 pipeline_select: 1'b0, addr: 9'h000};
      dout_q <= 8'h00;
      doe_q <= 1'b0;
    end else begin
      ctl_q.ras_n <= !ras_lo;
      ctl_q.cas_n <= !cas_lo;
      ctl_q.transfer_or_output_enable_n <= in_row ? lev.toe :
        (in_col ? (lev.toe && !rd_c) : 1'b1);
      ctl_q.write_per_bit_or_write_enable_n <= in_row ? lev.wpb :
        (in_col ? !wr_c : 1'b1);
      ctl_q.function_select_one <= in_row ? lev.fs1 :
        (in_col && cas_fs1);
      ctl_q.pipeline_select <= in_row && fam && pipe_q;
      ctl_q.addr <= in_row ? row_q : col_q;
      // Block write: data bits 3:0 are the column mask
      dout_q <= drv_mask ? mask_q : cdat_q;
      doe_q <= drv_mask || drv_data;
    end
  end

  assign dram_ctl = ctl_q;
  assign data_o = dout_q;
  assign data_oe = doe_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register read port, data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= 32'h0000_0000;
    end else if (rd_stat) begin
      rdata <= {16'h0000, rdat_q, 4'h0, stop_q, old_q, open_q, !idle};
    end else if (rd_data) begin
      rdata <= {16'h0000, mask_q, cdat_q};
    end else begin
      rdata <= 32'h0000_0000;
    end
  end
endmodule

// File: verif/vdram_host_checker.sv
// Pin-level assertions for the video DRAM port controller
`timescale 1ns/1ns
module vdram_host_checker
  import vdram_host_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire vdram_host_pkg::dram_ctl_t dram_ctl,
  input wire logic [7:0] data_o,
  input wire logic data_oe,
  input wire logic [7:0] data_i
);
  wire ras_n = dram_ctl.ras_n;
  wire cas_n = dram_ctl.cas_n;
  wire toe_n = dram_ctl.transfer_or_output_enable_n;
  wire wpb_n = dram_ctl.write_per_bit_or_write_enable_n;
  wire fs1 = dram_ctl.function_select_one;
  logic load_q;  // Open row is a register-load row
  logic old_q;  // Old mask mode seen on the pins
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Tracks mask mode from load and option-reset rows
  always_ff @(posedge clk) begin
    if (srst) begin
      load_q <= 1'b0;
      old_q <= 1'b0;
    end else begin
      if ($fell(ras_n)) load_q <= cas_n & toe_n & wpb_n & fs1;
      if ($fell(ras_n) & ~cas_n & ~fs1) old_q <= 1'b0;
      else if (load_q & ~ras_n & $fell(cas_n) & ~fs1) old_q <= 1'b1;
    end
  end
  ////////////////////////////////////////
  property p_row_addr;
    $fell(ras_n) |-> $stable(dram_ctl.addr);
  endproperty
  a_row_addr: assert property (p_row_addr) else $error("row address moved at row fall");
  property p_row_to_col;
    $fell(ras_n) && cas_n |-> cas_n [*6];
  endproperty
  a_row_to_col: assert property (p_row_to_col) else $error("column fell too early");
  property p_cbr;
    $fell(ras_n) && !cas_n |-> $past(cas_n, 2) == 1'b0;
  endproperty
  a_cbr: assert property (p_cbr) else $error("column not low ahead of row fall");
  property p_flash;
    $fell(ras_n) && cas_n && toe_n && !wpb_n && fs1 |-> cas_n [*8];
  endproperty
  a_flash: assert property (p_flash) else $error("flash row has a column cycle");
  property p_new_mask;
    $fell(ras_n) && cas_n && toe_n && !wpb_n && !old_q |-> data_oe && $past(data_oe);
  endproperty
  a_new_mask: assert property (p_new_mask) else $error("mask not driven at row fall");
  property p_col_addr;
    !ras_n && !cas_n && !$past(cas_n) |-> $stable(dram_ctl.addr);
  endproperty
  a_col_addr: assert property (p_col_addr) else $error("column address moved");
  property p_write_drive;
    !ras_n && $fell(wpb_n) |-> data_oe;
  endproperty
  a_write_drive: assert property (p_write_drive) else $error("write without data");
  property p_pipe;
    $fell(ras_n) && dram_ctl.pipeline_select |-> cas_n && toe_n && !fs1;
  endproperty
  a_pipe: assert property (p_pipe) else $error("pipeline select on a non-page row");
endmodule
bind vdram_host vdram_host_checker i_vdram_host_checker (.clk(clk), .srst(srst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .dram_ctl(dram_ctl), .data_o(data_o),
  .data_oe(data_oe), .data_i(data_i));

// File: verif/vdram_dev_model.sv
// Behavioural RAM port of the video DRAM
`timescale 1ns/1ns
module vdram_dev_model
  import vdram_host_pkg::*;
(
  input wire logic clk,
  input wire vdram_host_pkg::dram_ctl_t p,
  input wire logic [7:0] bus,
  output logic [7:0] dev_q,
  output vdram_host_pkg::op_t mode,
  output logic pipe,
  output logic old_mask,
  output logic bounds
);
  logic ras_q = 1'b1;
  logic cas_q = 1'b1;
  logic wpb_q = 1'b1;
  logic rd_q = 1'b0;  // Read data on the pins
  logic ram;  // Row opened a RAM port cycle
  logic we;
  op_t base;  // Row-time kind of the page
  logic [3:0] col;
  logic [3:0] rcol_q;
  logic [7:0] wm;  // Plane mask of the page
  logic [7:0] mask = 8'h00;
  logic [7:0] color = 8'h00;
  logic [7:0] last_q = 8'h00;
  logic [7:0] mem [16];
  wire wpb_n = p.write_per_bit_or_write_enable_n;
  wire fs1 = p.function_select_one;
  wire [3:0] lv = {p.cas_n, p.transfer_or_output_enable_n, wpb_n, fs1};
  initial foreach (mem[i]) mem[i] = 8'h00;
  // Released pins show the inverse of their last level
  assign dev_q = rd_q ? mem[rcol_q] : ~last_q;
  ////////////////////////////////////////
  // Decode at strobe falls, then masked writes
  always @(posedge clk) begin
    if (bus !== ~last_q) last_q <= bus;  // Released pins then stay at the inverse
    if (p.ras_n | p.transfer_or_output_enable_n) rd_q <= 1'b0;
    if (ras_q & ~p.ras_n) begin
      pipe = p.pipeline_select;
      ram = p.cas_n & p.transfer_or_output_enable_n;
      wm = wpb_n ? 8'hFF : old_mask ? mask : bus;
      casez (lv)
        4'b0??0: mode = refresh_with_option_reset;
        4'b0?01: mode = refresh_with_stop_set;
        4'b0?11: mode = refresh_only;
        4'b1000: mode = masked_write_transfer;
        4'b1001: mode = masked_split_write_transfer;
        4'b1010: mode = read_transfer;
        4'b1011: mode = split_read_transfer;
        4'b1100: mode = masked_read_write;
        4'b1101: mode = flash_write;
        4'b1110: mode = read_write;
        default: mode = load_write_mask;
      endcase
      if (mode == refresh_with_option_reset) old_mask = 1'b0;
      if (mode == refresh_with_option_reset) bounds = 1'b0;
      if (mode == refresh_with_stop_set) bounds = 1'b1;
      base = mode;
    end
    if (~p.ras_n & cas_q & ~p.cas_n & ram) begin
      col = p.addr[3:0];
      mode = fs1 ? op_t'(base + 4'h1) : base;
      rd_q <= wpb_n & ~fs1;
      rcol_q <= col;
    end
    we = ~p.ras_n & ~p.cas_n & ~wpb_n & (cas_q | wpb_q) & ram;
    if (we) begin
      case (mode)
        load_write_mask: old_mask = 1'b1;
        load_color: color = bus;
        masked_block_write, unmasked_block_write:
          for (int i = 0; i < 4; i++)
            if (bus[i]) mem[{col[3:2], 2'(i)}] <= (color & wm) | (mem[{col[3:2], 2'(i)}] & ~wm);
        default: mem[col] <= (bus & wm) | (mem[col] & ~wm);
      endcase
      if (mode == load_write_mask) mask = bus;
    end
    ras_q <= p.ras_n;
    cas_q <= p.cas_n;
    wpb_q <= wpb_n;
  end
endmodule

// File: verif/vdram_host_tb.sv
// Self-checking bench for the video DRAM port controller
`timescale 1ns/1ns
module vdram_host_tb;
  import vdram_host_pkg::*;
  localparam logic [7:0] WR = 8'(1 << CMD_WR);
  localparam logic [3:0] CM = 4'hB;  // Column mask for the block test
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [31:0] s;
  dram_ctl_t dram_ctl;
  logic [7:0] data_o, data_i, dev_q;
  logic data_oe, pipe, old_mask, bounds;
  op_t mode;
  int n_errors = 0;
  int tests_run = 0;
  // Rows: pipeline bit, kind, expected old mask and boundary flags
  localparam logic [6:0] ROWS [16] = '{{1'b0, refresh_with_option_reset, 2'b00},
    {1'b0, refresh_with_stop_set, 2'b01}, {1'b0, refresh_only, 2'b01},
    {1'b0, masked_write_transfer, 2'b01}, {1'b0, masked_split_write_transfer, 2'b01},
    {1'b0, read_transfer, 2'b01}, {1'b0, split_read_transfer, 2'b01},
    {1'b0, masked_read_write, 2'b01}, {1'b1, masked_read_write, 2'b01},
    {1'b0, masked_block_write, 2'b01}, {1'b0, flash_write, 2'b01},
    {1'b0, read_write, 2'b01}, {1'b1, unmasked_block_write, 2'b01},
    {1'b0, load_write_mask, 2'b11}, {1'b0, load_color, 2'b11},
    {1'b0, refresh_with_option_reset, 2'b00}};
  always #2 clk = ~clk;
  // Shared data wire: controller while enabled, else the device
  assign data_i = data_oe ? data_o : dev_q;
  vdram_host i_vdram_host (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .dram_ctl(dram_ctl), .data_o(data_o), .data_oe(data_oe),
    .data_i(data_i));
  vdram_dev_model i_vdram_dev_model (.clk(clk), .p(dram_ctl), .bus(data_i), .dev_q(dev_q),
    .mode(mode), .pipe(pipe), .old_mask(old_mask), .bounds(bounds));
  ////////////////////////////////////////
  task automatic tally_and_finish();
    if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rreg(input logic [7:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 s = rdata;
    @(posedge clk);
  endtask
  // One cycle kind, then poll status until idle
  task automatic op(input logic [31:0] a, input logic [31:0] d, input logic [7:0] c);
    wreg(OFF_ADDR, a);
    wreg(OFF_DATA, d);
    wreg(OFF_CMD, {24'h00_0000, c});
    for (int i = 0; i < 100; i++) begin
      rreg(OFF_STAT);
      if (s[0] === 1'b0) break;
    end
    chk("idle", s[0], 32'h0000_0000);
  endtask
  // Watchdog well beyond the expected run
  initial begin
    #100000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    #1;
    chk("ctl", dram_ctl, {4'hF, 11'h000});
    chk("oe", data_oe, 32'h0000_0000);
    @(posedge clk);
    foreach (ROWS[i]) begin
      op(32'h0000_0000, 32'h0000_0000, {3'b000, ROWS[i][6:2]});
      chk("mode", mode, ROWS[i][5:2]);
      chk("pipe", pipe, ROWS[i][6]);
      chk("old", old_mask, ROWS[i][1]);
      chk("bnd", bounds, ROWS[i][0]);
      chk("stat", {s[2], s[3]}, ROWS[i][1:0]);
    end
    // New mask write of column 3, then read it back
    op(32'h0000_0600, 32'h0000_0FA5, WR | 8'(masked_read_write));
    chk("nmask", i_vdram_dev_model.mem[3], 8'h05);
    op(32'h0000_0600, 32'h0000_0000, 8'(read_write));
    chk("rdat", s[15:8], 8'h05);
    // Loaded mask overrides the row-time pins
    op(32'h0000_0000, 32'h0000_00F0, 8'(load_write_mask));
    op(32'h0000_0800, 32'h0000_0FFF, WR | 8'(masked_read_write));
    chk("omask", i_vdram_dev_model.mem[4], 8'hF0);
    // Block write of the color into a masked column group
    op(32'h0000_0000, 32'h0000_003C, 8'(load_color));
    op(32'h0000_1000, {28'h000_0000, CM}, WR | 8'(unmasked_block_write));
    for (int j = 0; j < 4; j++)
      chk("blk", i_vdram_dev_model.mem[8 + j], {8{CM[j]}} & 8'h3C);
    // Page kept open, then a block write chosen at the next column
    op(32'h0000_0A00, 32'h0000_0011, WR | 8'(1 << CMD_KEEP) | 8'(read_write));
    chk("open", s[1], 32'h0000_0001);
    op(32'h0000_0C00, 32'h0000_0004, WR | 8'(1 << CMD_BLK) | 8'(read_write));
    chk("pgwr", i_vdram_dev_model.mem[5], 8'h11);
    chk("pgblk", i_vdram_dev_model.mem[6], 8'h3C);
    chk("shut", s[1], 32'h0000_0000);
    rreg(8'h10);
    chk("unmap", s, 32'h0000_0000);
    tally_and_finish();
  end
endmodule
